// [hw/cectx_map.svh]
// Register offsets, field positions, reset values and timing for the bus transmitter
`ifndef CECTX_MAP_SVH
`define CECTX_MAP_SVH

`define CECTX_A_UNIT_EN    4'h0
`define CECTX_A_SOFT_RST   4'h1
`define CECTX_A_TX_EN      4'h2
`define CECTX_A_TX_CTRL    4'h3
`define CECTX_A_TX_BUF     4'h4
`define CECTX_A_TX_STAT    4'h5
`define CECTX_A_RX_EN      4'h6

// Control register fields, and the EOM bit of the transmit buffer register
`define CECTX_F_FREE_LSB   0
`define CECTX_F_BRD        4
`define CECTX_F_STRS_LSB   8
`define CECTX_F_SPRD_LSB   12
`define CECTX_F_DTRS_LSB   16
`define CECTX_F_DPRD_LSB   20
`define CECTX_F_EOM        8

// Status bits
`define CECTX_S_STA        0
`define CECTX_S_END        1
`define CECTX_S_AL         2
`define CECTX_S_ACK        3
`define CECTX_S_UR         4
`define CECTX_S_BUSY       5

`define CECTX_CTRL_RST     21'h00_0000

// Sample tick: 100 MHz / 3126 (TICK_DIV + 1), just under 32 kHz nominal sampling clock
`define CECTX_TICK_DIV     12'hc35
// Reference timings in ticks (adjust fields subtract from all but CECTX_ACK_SAMPLE and CECTX_ARB_GUARD)
`define CECTX_START_LOW    8'h78
`define CECTX_START_PER    8'h90
`define CECTX_ZERO_LOW     8'h30
`define CECTX_ONE_LOW      8'h13
`define CECTX_BIT_PER      8'h4c
`define CECTX_ACK_SAMPLE   8'h21
`define CECTX_ARB_GUARD    8'h03

`endif

// [hw/cectx_pkg.sv]
// Types for the bus transmitter
package cectx_pkg;
   typedef enum logic [2:0] {
      CECTX_IDLE, CECTX_WAIT_FREE, CECTX_START, CECTX_BIT, CECTX_NEXT
   } cectx_state_t;

   typedef struct packed {
      logic       brd;
      logic [3:0] free;
      logic [3:0] strs;
      logic [3:0] sprd;
      logic [3:0] dtrs;
      logic [3:0] dprd;
   } cectx_ctrl_t;

   typedef struct packed {
      logic       eom;
      logic [7:0] data;
   } cectx_frame_t;
endpackage

// [hw/cectx_top.sv]
// Single-wire control bus transmitter with register port
`include "cectx_map.svh"

module cectx_top #(
   parameter int          DATA_BITS = 8,
   parameter logic [11:0] TICK_DIV  = `CECTX_TICK_DIV
) (
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic [3:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [31:0] rdata_o,
   input  wire logic        line_i,
   output logic             line_o,
   output logic             line_oe_o,
   output logic             rx_active_o
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] adj(input logic [7:0] ref_v, input logic [3:0] sub);
      adj = ref_v - {4'h0, sub};
   endfunction

   function automatic logic ack_bad(input logic brd, input logic lvl);
      ack_bad = brd ? !lvl : lvl;
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   cectx_pkg::cectx_state_t state, next_state;
   cectx_pkg::cectx_ctrl_t  ctrl, next_ctrl;
   cectx_pkg::cectx_frame_t buf_q, next_buf, shreg, next_shreg;
   logic        unit_enable, next_unit_enable;
   logic        tx_enable, next_tx_enable;
   logic        rx_enable, next_rx_enable;
   logic        buf_full, next_buf_full;
   logic [5:0]  stat, next_stat;
   logic [11:0] div, next_div;
   logic        tick, next_tick;
   logic [7:0]  tcnt, next_tcnt;
   logic [3:0]  bitn, next_bitn;
   logic [4:0]  idle_per, next_idle_per;
   logic [7:0]  idle_t, next_idle_t;
   logic        drive, next_drive;
   logic        line_d, next_line_d;
   logic        ack_err, next_ack_err;
   logic        ack_pend, next_ack_pend;
   logic [31:0] rdata, next_rdata;
   logic        cur_bit;
   logic [7:0]  low_len, per_len;

   always_comb
   begin
      case (bitn)
         4'h8:    cur_bit = shreg.eom;
         4'h9:    cur_bit = 1'b1;
         default: cur_bit = shreg.data[3'(7 - bitn)];
      endcase
      low_len = cur_bit ? adj(`CECTX_ONE_LOW, ctrl.dtrs) : adj(`CECTX_ZERO_LOW, ctrl.dtrs);
      per_len = adj(`CECTX_BIT_PER, ctrl.dprd);
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      next_state       = state;
      next_ctrl        = ctrl;
      next_buf         = buf_q;
      next_shreg       = shreg;
      next_unit_enable = unit_enable;
      next_tx_enable   = tx_enable;
      next_rx_enable   = rx_enable;
      next_buf_full    = buf_full;
      next_stat        = stat;
      next_tcnt        = tcnt;
      next_bitn        = bitn;
      next_idle_per    = idle_per;
      next_idle_t      = idle_t;
      next_drive       = drive;
      next_ack_err     = ack_err;
      next_ack_pend    = ack_pend;
      next_line_d      = line_i;
      next_rdata       = 32'h0000_0000;
      next_tick        = (div == TICK_DIV);
      next_div         = next_tick ? 12'h000 : div + 12'h001;

      if (rd_i)
      begin
         case (addr_i)
            `CECTX_A_UNIT_EN: next_rdata = {31'h0, unit_enable};
            `CECTX_A_TX_EN:   next_rdata = {31'h0, tx_enable};
            `CECTX_A_TX_CTRL: next_rdata = {8'h0, ctrl.dprd, ctrl.dtrs, ctrl.sprd,
                                            ctrl.strs, 3'h0, ctrl.brd, ctrl.free};
            `CECTX_A_TX_BUF:  next_rdata = {23'h0, buf_q};
            `CECTX_A_TX_STAT: next_rdata = {26'h0, stat};
            `CECTX_A_RX_EN:   next_rdata = {31'h0, rx_enable};
            default:          next_rdata = 32'h0000_0000;
         endcase
      end

      // Status bits 4:0 are read-to-clear; hardware sets below win
      if (rd_i && addr_i == `CECTX_A_TX_STAT)
         next_stat[4:0] = 5'h00;

      if (wr_i)
      begin
         case (addr_i)
            `CECTX_A_UNIT_EN: next_unit_enable = wdata_i[0];
            `CECTX_A_TX_EN:   next_tx_enable   = wdata_i[0];
            `CECTX_A_RX_EN:   next_rx_enable   = wdata_i[0];
            `CECTX_A_TX_CTRL:
            begin
               next_ctrl.free = wdata_i[`CECTX_F_FREE_LSB +: 4];
               next_ctrl.brd  = wdata_i[`CECTX_F_BRD];
               next_ctrl.strs = wdata_i[`CECTX_F_STRS_LSB +: 4];
               next_ctrl.sprd = wdata_i[`CECTX_F_SPRD_LSB +: 4];
               next_ctrl.dtrs = wdata_i[`CECTX_F_DTRS_LSB +: 4];
               next_ctrl.dprd = wdata_i[`CECTX_F_DPRD_LSB +: 4];
            end
            `CECTX_A_TX_BUF:
            begin
               next_buf      = {wdata_i[`CECTX_F_EOM], wdata_i[7:0]};
               next_buf_full = 1'b1;
            end
            default: ;
         endcase
      end

      // Idle tracker: a falling edge restarts, first period is a guard
      if (line_d && !line_i)
      begin
         next_idle_per = 5'h00;
         next_idle_t   = 8'h00;
      end
      else if (tick && line_i)
      begin
         if (idle_t == per_len)
         begin
            next_idle_t = 8'h00;
            if (idle_per != 5'h1f)
               next_idle_per = idle_per + 5'h01;
         end
         else
            next_idle_t = idle_t + 8'h01;
      end
      else if (tick && !line_i && !drive)
      begin
         next_idle_per = 5'h00;
         next_idle_t   = 8'h00;
      end

      if (tick)
         next_tcnt = tcnt + 8'h01;

      case (state)
         cectx_pkg::CECTX_IDLE:
            if (tx_enable && unit_enable)
               next_state = cectx_pkg::CECTX_WAIT_FREE;
         cectx_pkg::CECTX_WAIT_FREE:
            // Guard period plus 1..16 configured idle periods
            if (idle_per > 5'({1'b0, ctrl.free} + 5'h01))
            begin
               next_state = cectx_pkg::CECTX_START;
               next_tcnt  = 8'h00;
               next_drive = 1'b1;
            end
         cectx_pkg::CECTX_START:
            if (tick)
            begin
               if (tcnt == adj(`CECTX_START_LOW, ctrl.strs))
                  next_drive = 1'b0;
               if (tcnt == adj(`CECTX_START_LOW, ctrl.strs) + `CECTX_ARB_GUARD && !line_i)
               begin
                  next_stat[`CECTX_S_AL] = 1'b1;
                  next_state = cectx_pkg::CECTX_IDLE;
               end
               else if (tcnt == adj(`CECTX_START_PER, ctrl.sprd))
                  next_state = cectx_pkg::CECTX_NEXT;
            end
         cectx_pkg::CECTX_NEXT:
            if (!buf_full)
            begin
               next_stat[`CECTX_S_UR] = 1'b1;
               next_drive = 1'b0;
               next_state = cectx_pkg::CECTX_IDLE;
               next_ack_pend = ack_err;
               next_ack_err  = 1'b0;
            end
            else
            begin
               next_shreg    = buf_q;
               next_buf_full = 1'b0;
               next_stat[`CECTX_S_STA] = 1'b1;
               next_bitn  = 4'h0;
               next_tcnt  = 8'h00;
               next_drive = 1'b1;
               next_state = cectx_pkg::CECTX_BIT;
            end
         cectx_pkg::CECTX_BIT:
            if (tick)
            begin
               if (tcnt == low_len)
                  next_drive = 1'b0;
               if (bitn == 4'h9 && tcnt == `CECTX_ACK_SAMPLE)
                  next_ack_err = ack_bad(ctrl.brd, line_i);
               else if (bitn != 4'h9 && cur_bit && tcnt == low_len + `CECTX_ARB_GUARD
                        && !line_i)
               begin
                  next_stat[`CECTX_S_AL] = 1'b1;
                  next_state = cectx_pkg::CECTX_IDLE;
               end
               if (tcnt == per_len)
               begin
                  next_tcnt = 8'h00;
                  if (bitn == 4'h9)
                  begin
                     if (ack_err)
                     begin
                        // Underrun check first if more bytes follow
                        if (!shreg.eom && !buf_full)
                        begin
                           next_stat[`CECTX_S_UR] = 1'b1;
                           next_ack_pend = 1'b1;
                        end
                        else
                           next_stat[`CECTX_S_ACK] = 1'b1;
                        next_ack_err = 1'b0;
                        next_state   = cectx_pkg::CECTX_IDLE;
                     end
                     else if (shreg.eom)
                     begin
                        next_stat[`CECTX_S_END] = 1'b1;
                        next_state = cectx_pkg::CECTX_IDLE;
                     end
                     else
                        next_state = cectx_pkg::CECTX_NEXT;
                  end
                  else
                  begin
                     next_bitn  = bitn + 4'h1;
                     next_drive = 1'b1;
                  end
               end
            end
         default: next_state = cectx_pkg::CECTX_IDLE;
      endcase

      // Deferred ACK error, one cycle after the underrun report
      if (ack_pend && state == cectx_pkg::CECTX_IDLE)
      begin
         next_stat[`CECTX_S_ACK] = 1'b1;
         next_ack_pend = 1'b0;
      end

      // Leaving active states stops drive and clears enable
      if (next_state == cectx_pkg::CECTX_IDLE && state != cectx_pkg::CECTX_IDLE)
      begin
         next_drive     = 1'b0;
         next_tx_enable = 1'b0;
      end

      next_stat[`CECTX_S_BUSY] = (next_state != cectx_pkg::CECTX_IDLE);

      if (wr_i && addr_i == `CECTX_A_SOFT_RST && wdata_i[0])
      begin
         next_state     = cectx_pkg::CECTX_IDLE;
         next_ctrl      = `CECTX_CTRL_RST;
         next_buf       = '0;
         next_shreg     = '0;
         next_tx_enable = 1'b0;
         next_rx_enable = 1'b0;
         next_buf_full  = 1'b0;
         next_stat      = 6'h00;
         next_drive     = 1'b0;
         next_ack_err   = 1'b0;
         next_ack_pend  = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state       <= cectx_pkg::CECTX_IDLE;
         ctrl        <= `CECTX_CTRL_RST;
         buf_q       <= '0;
         shreg       <= '0;
         unit_enable <= 1'b0;
         tx_enable   <= 1'b0;
         rx_enable   <= 1'b0;
         buf_full    <= 1'b0;
         stat        <= 6'h00;
         div         <= 12'h000;
         tick        <= 1'b0;
         tcnt        <= 8'h00;
         bitn        <= 4'h0;
         idle_per    <= 5'h00;
         idle_t      <= 8'h00;
         drive       <= 1'b0;
         line_d      <= 1'b1;
         ack_err     <= 1'b0;
         ack_pend    <= 1'b0;
         rdata       <= 32'h0000_0000;
         rx_active_o <= 1'b0;
      end
      else
      begin
         state       <= next_state;
         ctrl        <= next_ctrl;
         buf_q       <= next_buf;
         shreg       <= next_shreg;
         unit_enable <= next_unit_enable;
         tx_enable   <= next_tx_enable;
         rx_enable   <= next_rx_enable;
         buf_full    <= next_buf_full;
         stat        <= next_stat;
         div         <= next_div;
         tick        <= next_tick;
         tcnt        <= next_tcnt;
         bitn        <= next_bitn;
         idle_per    <= next_idle_per;
         idle_t      <= next_idle_t;
         drive       <= next_drive;
         line_d      <= next_line_d;
         ack_err     <= next_ack_err;
         ack_pend    <= next_ack_pend;
         rdata       <= next_rdata;
         // Receiver gated off while sending
         rx_active_o <= next_rx_enable && next_unit_enable
                        && (next_state == cectx_pkg::CECTX_IDLE);
      end
   end

   assign rdata_o   = rdata;
   assign line_o    = 1'b0;
   assign line_oe_o = drive;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   done_clears_en_a: assert property ($rose(stat[`CECTX_S_END]) |-> !tx_enable)
      else $error("done without enable clear");
   done_needs_eom_a: assert property ($rose(stat[`CECTX_S_END]) |-> shreg.eom)
      else $error("done on non-final byte");
   ur_stops_drive_a: assert property ($rose(stat[`CECTX_S_UR]) |-> !line_oe_o)
      else $error("drive after underrun");
   al_stops_a: assert property ($rose(stat[`CECTX_S_AL]) |-> !line_oe_o && !tx_enable)
      else $error("drive after arbitration loss");
   ack_after_ur_a: assert property (ack_pend && state == cectx_pkg::CECTX_IDLE
                                    |=> stat[`CECTX_S_ACK])
      else $error("ack error not reported after underrun");
   no_rx_tx_a: assert property (state != cectx_pkg::CECTX_IDLE |-> !rx_active_o)
      else $error("receive during transmit");
   sta_loads_a: assert property (state == cectx_pkg::CECTX_NEXT && buf_full
                                 |=> !buf_full && stat[`CECTX_S_STA])
      else $error("buffer not moved");
   srst_idle_a: assert property (wr_i && addr_i == `CECTX_A_SOFT_RST && wdata_i[0]
                                 |=> !line_oe_o && !tx_enable && ctrl == '0)
      else $error("soft reset incomplete");
   start_free_a: assert property ($rose(state == cectx_pkg::CECTX_START)
                                  |-> $past(idle_per) > 5'({1'b0, ctrl.free} + 5'h01))
      else $error("start before bus free");

   done_c: cover property ($rose(stat[`CECTX_S_END]));
   ack_c:  cover property ($rose(stat[`CECTX_S_ACK]));
   ur_c:   cover property ($rose(stat[`CECTX_S_UR]));
   al_c:   cover property ($rose(stat[`CECTX_S_AL]));

endmodule // cectx_top

// [test/cec_bus_transmitter_tb.sv]
// Self-checking bench for the control bus transmitter
`include "cectx_map.svh"
module cec_bus_transmitter_tb;
   timeunit 1ns;
   timeprecision 1ns;

   // Shortened sample tick keeps the run small; all timing scales with it
   localparam int          TICK = 4;
   localparam int          BITP = 61;
   localparam logic [31:0] CTRL = 32'h00f0_f000;

   logic        core_clk_i;
   logic        rst_n_i;
   logic [3:0]  addr_i;
   logic [31:0] wdata_i;
   logic        wr_i;
   logic        rd_i;
   logic [31:0] rdata_o;
   logic        line_o;
   logic        line_oe_o;
   logic        rx_active_o;
   logic        pull;
   logic        ack_low;
   logic        jam;
   wire         line = !((line_oe_o && !line_o) || pull);
   int          num_errors;
   int          samples_checked;
   int          low_len;
   int          nbits;
   int          n;
   int          since_low;
   int          gap;
   logic [19:0] wbits;
   logic [31:0] s;
   logic [4:0]  acc;

   cectx_top #(.DATA_BITS(8), .TICK_DIV(12'(TICK - 1))) uut (.core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .line_i(line), .line_o(line_o), .line_oe_o(line_oe_o), .rx_active_o(rx_active_o));
   cectx_bus_partner #(.TICK(TICK)) far (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
      .line_i(line), .ack_low_i(ack_low), .jam_i(jam), .pull_o(pull));

   initial
   begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end

   // Decode own low pulses: long is start, short is one
   always @(posedge core_clk_i)
   begin
      since_low <= line ? since_low + 1 : 0;
      // Line-high time just before our own drive begins
      if (line_oe_o && low_len == 0)
         gap <= since_low;
      if (line_oe_o)
         low_len <= low_len + 1;
      else if (low_len != 0)
      begin
         if (low_len > 100 * TICK)
         begin
            nbits <= 0;
            wbits <= '0;
         end
         else
         begin
            nbits <= nbits + 1;
            wbits <= {wbits[18:0], low_len < 33 * TICK};
         end
         low_len <= 0;
      end
   end

   // ----------------------------------------
   // Access tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge core_clk_i);
      wr_i    <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge core_clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge core_clk_i);
      rd_i   <= 1'b0;
      #1 d = rdata_o;
   endtask

   task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd(a, d);
      chk(d, exp);
   endtask

   // Status reads clear the event bits, so they are gathered here
   task automatic poll(input logic [4:0] mask, input logic need_idle);
      acc = '0;
      for (int i = 0; i < 10000; i++)
      begin
         rd(`CECTX_A_TX_STAT, s);
         acc |= s[4:0];
         if (s[5] && acc[0])
            chk({31'h0, rx_active_o}, 32'h0);
         if ((acc & mask) != 0 && !(need_idle && s[5]))
            return;
         repeat (1000) @(posedge core_clk_i);
      end
      chk({27'h0, acc}, {27'h0, mask});
   endtask

   task automatic wait_drive(output int c);
      c = 0;
      while (!line_oe_o && c < 20_000)
      begin
         @(posedge core_clk_i);
         c++;
      end
   endtask

   task automatic send(input logic brd, input logic ackl, input logic [8:0] word);
      ack_low <= ackl;
      wr(`CECTX_A_TX_CTRL, CTRL | {27'h0, brd, 4'h0});
      wr(`CECTX_A_TX_BUF, {23'h0, word});
      wr(`CECTX_A_TX_EN, 32'h1);
   endtask

   task automatic end_sim();
      $display("checks=%0d errors=%0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial
   begin
      rst_n_i = 1'b0;
      addr_i = '0;
      wdata_i = '0;
      wr_i = 1'b0;
      rd_i = 1'b0;
      jam = 1'b0;
      ack_low = 1'b0;
      low_len = 0;
      since_low = 0;
      gap = 0;
      nbits = 0;
      wbits = '0;
      num_errors = 0;
      samples_checked = 0;
      repeat (3) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      for (int a = 0; a < 7; a++)
         rchk(a[3:0], 32'h0);
      wr(4'hf, 32'hffff_ffff);
      rchk(4'hf, 32'h0);
      wr(`CECTX_A_UNIT_EN, 32'h1);
      wr(`CECTX_A_RX_EN, 32'h1);
      $display("test reset_map done");

      // All broadcast and ACK response pairings
      for (int c = 0; c < 4; c++)
      begin
         send(c[1], c[0], {1'b1, 8'ha5 ^ c[7:0]});
         wait_drive(n);
         rchk(`CECTX_A_TX_EN, 32'h1);
         chk({31'h0, gap >= 2 * BITP * TICK && n <= 3 * BITP * TICK}, 32'h1);
         if (c == 0)
            rchk(`CECTX_A_TX_CTRL, CTRL);
         poll(5'b11110, 1'b1);
         chk({27'h0, acc}, (c[1] ^ c[0]) ? 32'h3 : 32'h9);
         chk({22'h0, wbits[9:0]}, {22'h0, 8'ha5 ^ c[7:0], 2'b11});
         chk(32'(nbits), 32'd10);
         rchk(`CECTX_A_TX_EN, 32'h0);
         chk({29'h0, rx_active_o, line_o, line_oe_o}, 32'h4);
      end
      $display("test ack_table done");

      send(1'b0, 1'b1, 9'h03c);
      poll(5'b00001, 1'b0);
      rchk(`CECTX_A_TX_EN, 32'h1);
      wr(`CECTX_A_TX_BUF, 32'h1c3);
      poll(5'b11110, 1'b1);
      chk({27'h0, acc}, 32'h3);
      chk({12'h0, wbits}, {12'h0, 8'h3c, 2'b01, 8'hc3, 2'b11});
      chk(32'(nbits), 32'd20);
      $display("test two_bytes done");

      // Second byte never loaded and no ACK given
      send(1'b0, 1'b0, 9'h05a);
      poll(5'b00001, 1'b0);
      poll(5'b11110, 1'b1);
      // Deferred ACK flag lands one cycle after the underrun flag
      rd(`CECTX_A_TX_STAT, s);
      acc |= s[4:0];
      chk({27'h0, acc}, 32'h18);
      rchk(`CECTX_A_TX_EN, 32'h0);
      $display("test underrun done");

      // Busy line delays start; held low during start bit loses arbitration
      jam <= 1'b1;
      send(1'b0, 1'b1, 9'h1ff);
      repeat (3 * BITP * TICK) @(posedge core_clk_i);
      chk({31'h0, line_oe_o}, 32'h0);
      jam <= 1'b0;
      wait_drive(n);
      jam <= 1'b1;
      poll(5'b11110, 1'b1);
      jam <= 1'b0;
      chk({31'h0, gap >= 2 * BITP * TICK && n < 20_000}, 32'h1);
      chk({27'h0, acc}, 32'h4);
      chk({30'h0, line_o, line_oe_o}, 32'h0);
      rchk(`CECTX_A_TX_EN, 32'h0);
      $display("test arbitration done");

      send(1'b1, 1'b0, 9'h100);
      wait_drive(n);
      wr(`CECTX_A_SOFT_RST, 32'h1);
      repeat (2) @(posedge core_clk_i);
      #1 chk({31'h0, line_oe_o}, 32'h0);
      rchk(`CECTX_A_TX_EN, 32'h0);
      rchk(`CECTX_A_TX_CTRL, 32'h0);
      rchk(`CECTX_A_UNIT_EN, 32'h1);
      $display("test soft_reset done");
      end_sim();
   end

   initial
   begin
      #(64'd1_000_000);
      num_errors++;
      end_sim();
   end
endmodule // cec_bus_transmitter_tb

// [test/cectx_bus_partner.sv]
// Model of another station sharing the open-drain control line
module cectx_bus_partner #(
   parameter int TICK = 3125
) (
   input  wire logic core_clk_i,
   input  wire logic rst_n_i,
   input  wire logic line_i,
   input  wire logic ack_low_i,
   input  wire logic jam_i,
   output logic      pull_o
);
   timeunit 1ns;
   timeprecision 1ns;

   logic        prev;
   int unsigned edges;
   int unsigned idle;
   int unsigned hold;

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         prev  <= 1'b1;
         edges <= 0;
         idle  <= 0;
         hold  <= 0;
      end
      else
      begin
         prev <= line_i;
         idle <= line_i ? idle + 1 : 0;
         // Long high gap ends a message; frame gaps are far shorter
         if (idle > 100 * TICK)
            edges <= 0;
         if (prev && !line_i)
         begin
            edges <= edges + 1;
            // Every tenth edge after the start edge opens an ACK slot
            if (ack_low_i && edges > 0 && edges % 10 == 0)
               hold <= 48 * TICK;
         end
         else if (hold != 0)
            hold <= hold - 1;
      end
   end

   // Only ever pulls low; the pull-up restores the line
   assign pull_o = jam_i || hold != 0;
endmodule // cectx_bus_partner
